// *** acgc_consts.vh ***
// constants for the converter front-end configuration block
// assumes an apb slave on a 250 MHz clock; offsets are register indices
// Notes on behaviour
// - channel 1 gain is 2 to the power of its 3-bit code, 1 up to 128.
// - channel 0 gain is 2 to the power of its own 3-bit code, 1 up to 128.
// - the 4-bit chop delay code selects 2 shl code modulator periods.
// - with chop on, each measurement waits the delay before accumulating.
// - one enable bit turns chop off at 0 and on at 1, and resets to 0.
// - channel 0 select: 0 pair, 1 shorted, 2 positive test, 3 negative test.
// - channel 1 select offers the same four choices as channel 0.
`ifndef ACGC_CONSTS_VH
`define ACGC_CONSTS_VH
`define ACGC_IDX_GAIN 6'h04
`define ACGC_IDX_CHOP 6'h06
`define ACGC_IDX_CH0 6'h09
`define ACGC_IDX_CH1 6'h0E
`define ACGC_RST_GAIN 16'h0000
`define ACGC_RST_CHOP 16'h0600
`define ACGC_RST_CH 16'h0000
`define ACGC_GAIN_WMASK 16'hFFFF
`define ACGC_CHOP_WMASK 16'hFFFF
`define ACGC_CH_WMASK 16'hFFC7
`define ACGC_GAIN1_LSB 4
`define ACGC_GAIN0_LSB 0
`define ACGC_DLY_LSB 9
`define ACGC_EN_BIT 8
`define ACGC_SEL_LSB 0
`define ACGC_DLY_BASE 18'h00002
`endif

// *** acgc_top.v ***
// front-end configuration registers and chop settle timer
// assumes apb master on SYS_CLK; MOD_TICK is a modulator-period strobe
`include "acgc_consts.vh"

// two-flop synchroniser for a level from another domain
module acgc_sync #(
    parameter RST_LVL = 1'b0
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // level in, synchronised level out
    input wire d,
    output wire q
);
    reg meta_q;
    reg sync_q;

    // only sync_q leaves; meta_q may still be settling
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_LVL;
            sync_q <= RST_LVL;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;
endmodule // acgc_sync

// one-hot gain from a 3-bit code, doubling per step
module acgc_gain_dec (
    // gain code
    input wire [2:0] code,
    // one-hot gain, 1 up to 128
    output reg [7:0] gain
);
    always @* begin
        case (code)
            3'h0: begin
                gain = 8'h01;
            end
            3'h1: begin
                gain = 8'h02;
            end
            3'h2: begin
                gain = 8'h04;
            end
            3'h3: begin
                gain = 8'h08;
            end
            3'h4: begin
                gain = 8'h10;
            end
            3'h5: begin
                gain = 8'h20;
            end
            3'h6: begin
                gain = 8'h40;
            end
            3'h7: begin
                gain = 8'h80;
            end
            default: begin
                gain = 8'h01;
            end
        endcase
    end
endmodule // acgc_gain_dec

module acgc_top (
    // clock and reset
    input wire SYS_CLK,
    input wire RST_N,
    // apb
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output wire [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    // converter timing
    input wire MOD_TICK,
    input wire MEAS_REQ,
    // front-end steering
    output reg [7:0] CH0_GAIN,
    output reg [7:0] CH1_GAIN,
    output reg [1:0] CH0_SEL,
    output reg [1:0] CH1_SEL,
    output reg CHOP_ON,
    output reg SETTLING,
    output reg ACCUM_EN
);
    // register file
    reg [15:0] gain_q;
    reg [15:0] chop_q;
    reg [15:0] ch0_q;
    reg [15:0] ch1_q;
    reg [31:0] rdata_q;
    // settle timer
    reg [17:0] cnt_q;
    reg tick_s3_q;
    // bus decode
    wire [5:0] idx;
    wire aligned;
    wire hit;
    wire wr;
    wire setup;
    // synchronised pins
    wire tick_s2;
    wire req_s2;
    wire tick;
    // chop fields
    wire chop_en;
    wire [3:0] dly_code;
    wire [17:0] dly_periods;
    // decoded gains
    wire [7:0] ch0_gain_d;
    wire [7:0] ch1_gain_d;

    assign idx = PADDR[7:2];
    assign aligned = (PADDR[1:0] == 2'h0);
    assign hit = (idx == `ACGC_IDX_GAIN) ||
                 (idx == `ACGC_IDX_CHOP) ||
                 (idx == `ACGC_IDX_CH0) ||
                 (idx == `ACGC_IDX_CH1);
    assign setup = PSEL && !PENABLE;
    assign wr = PSEL && PENABLE && PWRITE && hit && aligned;
    assign chop_en = chop_q[`ACGC_EN_BIT];
    assign dly_code = chop_q[`ACGC_DLY_LSB+3:`ACGC_DLY_LSB];
    // widest code gives 65536, which still fits the 18-bit counter
    assign dly_periods = `ACGC_DLY_BASE << dly_code;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !(hit && aligned);
    assign PRDATA = rdata_q;

    // modulator tick and request come from another domain
    acgc_sync #(
        .RST_LVL(1'b0)
    ) acgc_sync_tick_i (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .d(MOD_TICK),
        .q(tick_s2)
    );

    acgc_sync #(
        .RST_LVL(1'b0)
    ) acgc_sync_req_i (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .d(MEAS_REQ),
        .q(req_s2)
    );

    // gain codes to one-hot
    acgc_gain_dec acgc_gain_dec_ch0_i (
        .code(gain_q[`ACGC_GAIN0_LSB+2:`ACGC_GAIN0_LSB]),
        .gain(ch0_gain_d)
    );

    acgc_gain_dec acgc_gain_dec_ch1_i (
        .code(gain_q[`ACGC_GAIN1_LSB+2:`ACGC_GAIN1_LSB]),
        .gain(ch1_gain_d)
    );

    // gain register; reserved bits stored as written
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            gain_q <= `ACGC_RST_GAIN;
        end else if (wr && idx == `ACGC_IDX_GAIN) begin
            gain_q <= PWDATA[15:0] & `ACGC_GAIN_WMASK;
        end
    end

    // chop register
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            chop_q <= `ACGC_RST_CHOP;
        end else if (wr && idx == `ACGC_IDX_CHOP) begin
            chop_q <= PWDATA[15:0] & `ACGC_CHOP_WMASK;
        end
    end

    // channel registers; read-only reserved bits held at zero
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ch0_q <= `ACGC_RST_CH;
        end else if (wr && idx == `ACGC_IDX_CH0) begin
            ch0_q <= PWDATA[15:0] & `ACGC_CH_WMASK;
        end
    end

    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ch1_q <= `ACGC_RST_CH;
        end else if (wr && idx == `ACGC_IDX_CH1) begin
            ch1_q <= PWDATA[15:0] & `ACGC_CH_WMASK;
        end
    end

    // read data registered during setup so it stands in access phase
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q <= 32'h00000000;
        end else if (setup) begin
            case (idx)
                `ACGC_IDX_GAIN: begin
                    rdata_q <= {16'h0000, gain_q};
                end
                `ACGC_IDX_CHOP: begin
                    rdata_q <= {16'h0000, chop_q};
                end
                `ACGC_IDX_CH0: begin
                    rdata_q <= {16'h0000, ch0_q};
                end
                `ACGC_IDX_CH1: begin
                    rdata_q <= {16'h0000, ch1_q};
                end
                default: begin
                    rdata_q <= 32'h00000000;
                end
            endcase
        end
    end

    // decoded steering outputs
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            CH0_GAIN <= 8'h01;
            CH1_GAIN <= 8'h01;
            CH0_SEL <= 2'h0;
            CH1_SEL <= 2'h0;
            CHOP_ON <= 1'b0;
        end else begin
            CH1_GAIN <= ch1_gain_d;
            CH0_GAIN <= ch0_gain_d;
            CH0_SEL <= ch0_q[`ACGC_SEL_LSB+1:`ACGC_SEL_LSB];
            CH1_SEL <= ch1_q[`ACGC_SEL_LSB+1:`ACGC_SEL_LSB];
            CHOP_ON <= chop_en;
        end
    end

    // edge detect on the synchronised tick, idle low like the pin
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            tick_s3_q <= 1'b0;
        end else begin
            tick_s3_q <= tick_s2;
        end
    end

    assign tick = tick_s2 && !tick_s3_q;

    // settle timer; a new request restarts the wait
    always @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_q <= 18'h00000;
            SETTLING <= 1'b0;
            ACCUM_EN <= 1'b0;
        end else if (!req_s2) begin
            SETTLING <= 1'b0;
            ACCUM_EN <= 1'b0;
            cnt_q <= 18'h00000;
        end else if (!chop_en) begin
            SETTLING <= 1'b0;
            ACCUM_EN <= 1'b1;
        end else if (!SETTLING && !ACCUM_EN) begin
            SETTLING <= 1'b1;
            cnt_q <= dly_periods;
        end else if (SETTLING && tick) begin
            if (cnt_q == 18'h00001) begin
                SETTLING <= 1'b0;
                ACCUM_EN <= 1'b1;
            end
            cnt_q <= cnt_q - 18'h00001;
        end
    end
endmodule // acgc_top

// *** acgc_top_sva.sv ***
// port assertions for the front-end config block
// assumes acgc_top ports, one clock
module acgc_sva (input SYS_CLK, RST_N, PSEL, PENABLE, PWRITE,
    input MOD_TICK, MEAS_REQ, PREADY, PSLVERR, CHOP_ON, SETTLING, ACCUM_EN,
    input [7:0] PADDR, CH0_GAIN, CH1_GAIN, input [1:0] CH0_SEL, CH1_SEL,
    input [31:0] PWDATA, PRDATA);
timeunit 1ns; timeprecision 1ps;
default clocking @(posedge SYS_CLK); endclocking
default disable iff (!RST_N);
wire wr = PSEL & PENABLE & PWRITE;
logic tk_q; logic [3:0] dly_q; logic [17:0] cnt_q;
// ticks seen here lead the design by its sync, so allow one either way
always_ff @(posedge SYS_CLK or negedge RST_N)
    if (!RST_N) begin
        tk_q <= 0; dly_q <= 4'h3; cnt_q <= 0;
    end else begin
        tk_q <= MOD_TICK;
        if (wr && PADDR == 8'h18) dly_q <= PWDATA[12:9];
        cnt_q <= !SETTLING ? 18'h0 : cnt_q + 18'(MOD_TICK & ~tk_q);
    end
gain1_map_a: assert property ($past(wr && PADDR == 8'h10, 2) |->
    CH1_GAIN == 8'h01 << $past(PWDATA[6:4], 2)) else $error("ch1 gain");
gain0_map_a: assert property ($past(wr && PADDR == 8'h10, 2) |->
    CH0_GAIN == 8'h01 << $past(PWDATA[2:0], 2)) else $error("ch0 gain");
settle_len_a: assert property ($rose(ACCUM_EN) && CHOP_ON |->
    cnt_q + 1 >= (18'h2 << dly_q) && cnt_q <= (18'h2 << dly_q) + 1)
    else $error("settle length");
settle_first_a: assert property ($rose(ACCUM_EN) && CHOP_ON |->
    $past(SETTLING)) else $error("accumulate before settle");
chop_bit_a: assert property ($past(wr && PADDR == 8'h18, 2) |->
    CHOP_ON == $past(PWDATA[8], 2)) else $error("chop enable");
sel0_map_a: assert property ($past(wr && PADDR == 8'h24, 2) |->
    CH0_SEL == $past(PWDATA[1:0], 2)) else $error("ch0 select");
sel1_map_a: assert property ($past(wr && PADDR == 8'h38, 2) |->
    CH1_SEL == $past(PWDATA[1:0], 2)) else $error("ch1 select");
ro_zero_a: assert property (PSEL && PENABLE && (PADDR == 8'h24 ||
    PADDR == 8'h38) |-> PRDATA[5:3] == 3'h0) else $error("reserved read");
cover property ($rose(ACCUM_EN) && CHOP_ON);
cover property ($rose(SETTLING));
cover property (PSEL && PENABLE && PSLVERR);
endmodule // acgc_sva
bind acgc_top acgc_sva acgc_sva_i (.*);

// *** tb.sv ***
// self-checking bench for the front-end config block
// assumes acgc_top with a zero-wait apb slave
module tb;
timeunit 1ns; timeprecision 1ps;
logic SYS_CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
logic MOD_TICK = 0, MEAS_REQ = 0, PREADY, PSLVERR;
logic CHOP_ON, SETTLING, ACCUM_EN;
logic [7:0] PADDR = 0, CH0_GAIN, CH1_GAIN;
logic [31:0] PWDATA = 0, PRDATA;
logic [1:0] CH0_SEL, CH1_SEL;
logic [2:0] tc = 0;
logic seen = 0;
logic [32:0] q[$];
int num_errors = 0, total_checks = 0;
acgc_top acgc_top_i (.*);
initial forever #2 SYS_CLK = ~SYS_CLK;
// modulator period of 8 clocks keeps each level well over 2 cycles
always @(posedge SYS_CLK) begin
    tc <= tc + 3'h1;
    MOD_TICK <= tc[2];
end
task chk(string n, logic [32:0] s, logic [32:0] e);
    total_checks++;
    if (s !== e) begin
        num_errors++;
        $display("unexpected %s exp %h got %h", n, e, s);
    end
endtask
always @(posedge SYS_CLK)
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE)
        chk("read", {PSLVERR, PRDATA}, q.pop_front());
// reads carry the expected {error, data} in d
task apb(logic w, logic [7:0] a, logic [32:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1; PWRITE <= w; PADDR <= a; PWDATA <= d[31:0];
    if (!w) q.push_back(d);
    @(posedge SYS_CLK);
    PENABLE <= 1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    PSEL <= 0; PENABLE <= 0;
endtask
// after the read back the steering outputs have long settled
task wr(logic [7:0] a, logic [32:0] v);
    apb(1, a, v);
    apb(0, a, v);
    if (a == 8'h10) begin
        chk("gain0", CH0_GAIN, 33'(8'h01 << v[2:0]));
        chk("gain1", CH1_GAIN, 33'(8'h01 << v[6:4]));
    end else if (a == 8'h18) begin
        chk("chop", CHOP_ON, v[8]);
    end else if (a == 8'h24) begin
        chk("sel0", CH0_SEL, v[1:0]);
    end else if (a == 8'h38) begin
        chk("sel1", CH1_SEL, v[1:0]);
    end
endtask
task conclude;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
endtask
initial begin
    #40000;
    num_errors++;
    conclude;
end
initial begin
    void'($urandom(24825));
    repeat (3) @(posedge SYS_CLK);
    RST_N <= 1;
    apb(0, 8'h18, 33'h600);
    apb(0, 8'h10, 0);
    apb(0, 8'h24, 0);
    apb(0, 8'h38, 0);
    apb(0, 8'h20, 33'h100000000);
    apb(0, 8'h11, 33'h100000000);
    for (int i = 0; i < 8; i++) wr(8'h10, 33'(i * 16 + $urandom % 8));
    for (int i = 0; i < 4; i++) begin
        wr(8'h24, 33'(i));
        wr(8'h38, 33'(3 - i));
    end
    // last pass has chop off, so accumulation must follow at once
    for (int c = 0; c < 5; c++) begin
        wr(8'h18, 33'(c < 4 ? c * 512 + 256 : 1536));
        MEAS_REQ <= 1;
        seen = 0;
        for (int k = 0; k < (c < 4 ? 900 : 6) && ACCUM_EN !== 1'b1;
                k++) begin
            seen |= SETTLING;
            @(posedge SYS_CLK);
        end
        chk("accum", ACCUM_EN, 1);
        chk("settle", seen, 33'(c < 4));
        MEAS_REQ <= 0;
        repeat (8) @(posedge SYS_CLK);
    end
    conclude;
end
endmodule // tb
